// *** pkg/spd_pkg.sv ***
// constants and types of the serial program download port
// Function
// - programming only accepted while the reset pin is held low
// - nothing programs or erases until the enable instruction has executed
// - an eeprom byte write erases its location first, self-timed
// - chip erase sets every flash and eeprom location to all ones
// - serial data in is sampled on the rising clock edge
// - serial data out is shifted on the falling clock edge
// - second enable byte echoes while the third byte shifts in
// - page buffer loads one byte per instruction, five low address bits
// - write-page commits whole buffer at page from seven upper address bits
// - eeprom programs one byte per instruction carrying address and data
// - read instruction shifts the addressed location out on serial data out
// - reads inside a flash page being written return all ones
// - read of an eeprom byte being written returns all ones
// - reset pin high ends programming mode
// - enable instruction is 0xAC, 0x53, then two don't-care bytes
// - chip erase is 0xAC then second byte with upper bits 100
// - write page is 0x4C with page address in bytes two and three
// - eeprom write is 0xC0 with address in bytes two, three, data in four
package spd_pkg;
  // instruction byte codes
  localparam logic [7:0] SPD_B1_ENABLE = 8'hAC;
  localparam logic [7:0] SPD_B2_ENABLE = 8'h53;
  localparam logic [2:0] SPD_B2_ERASE = 3'h4;
  localparam logic [7:0] SPD_B1_RD_FL = 8'h20;
  localparam logic [7:0] SPD_B1_LD_PG = 8'h40;
  localparam logic [7:0] SPD_B1_WR_PG = 8'h4C;
  localparam logic [7:0] SPD_B1_RD_EE = 8'hA0;
  localparam logic [7:0] SPD_B1_WR_EE = 8'hC0;
  localparam logic [7:0] SPD_HI_BIT_MASK = 8'h08;
  localparam logic [7:0] SPD_ERASED = 8'hFF;
  localparam logic [7:0] SPD_ZERO = 8'h00;
  // field widths and positions
  localparam int SPD_FL_AW = 12;
  localparam int SPD_EE_AW = 9;
  localparam int SPD_IDX_W = 5;
  localparam int SPD_PAGE_W = 7;
  localparam int SPD_PAGE_WORDS = 32;
  localparam int SPD_CNT_W = 22;
  // array operations
  typedef enum logic [1:0] {SPD_OP_FL_WORD, SPD_OP_EE_ERASE, SPD_OP_EE_WRITE,
    SPD_OP_CHIP_ERASE} spd_op_t;
  localparam int SPD_BUF_W = 2 + SPD_FL_AW + 16;
  // self-timed write durations
  localparam int SPD_CLK_PS = 5000;
  localparam longint FLASH_PAGE_WAIT_DELAY_PS = 64'd4500000000;
  localparam longint EEPROM_BYTE_WAIT_DELAY_PS = 64'd9000000000;
  localparam longint CHIP_ERASE_WAIT_DELAY_PS = 64'd9000000000;
  localparam int SPD_FLASH_CYC = int'((FLASH_PAGE_WAIT_DELAY_PS + SPD_CLK_PS - 1) / SPD_CLK_PS);
  localparam int SPD_EE_CYC = int'((EEPROM_BYTE_WAIT_DELAY_PS + SPD_CLK_PS - 1) / SPD_CLK_PS);
  localparam int SPD_ERASE_CYC = int'((CHIP_ERASE_WAIT_DELAY_PS + SPD_CLK_PS - 1) / SPD_CLK_PS);
endpackage

// *** design/spd_buf.sv ***
// two-entry valid/ready buffer on the array write path
`timescale 1ns/1ps
`default_nettype none
module spd_buf #(
  parameter int W = 30,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // full and empty come straight from the count, so back-pressure is honest
  assign in_ready = (cnt_r != 2'(DEPTH));
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // spd_buf
`default_nettype wire

// *** design/spd_top.sv ***
// serial program download port: spi-style link to the flash and eeprom arrays
`timescale 1ns/1ps
`default_nettype none
module spd_top #(
  parameter int FLASH_CYC = spd_pkg::SPD_FLASH_CYC,
  parameter int EE_CYC = spd_pkg::SPD_EE_CYC,
  parameter int ERASE_CYC = spd_pkg::SPD_ERASE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // array write port
  output logic nvm_valid,
  input wire logic nvm_ready,
  output logic [1:0] nvm_op,
  output logic [spd_pkg::SPD_FL_AW-1:0] nvm_addr,
  output logic [15:0] nvm_data,
  // array read port
  output logic [spd_pkg::SPD_FL_AW-1:0] rd_addr,
  output logic rd_ee,
  input wire logic [15:0] fl_rd_data,
  input wire logic [7:0] ee_rd_data,
  // status
  output logic prog_mode,
  output logic busy
);
  typedef enum logic [2:0] {S_IDLE, S_PAGE, S_EE_ERASE, S_EE_WRITE, S_ERASE} spd_state_t;
  typedef enum logic [1:0] {BK_FLASH, BK_EE, BK_ERASE} spd_busy_t;
  localparam int SPD_CNT_W = spd_pkg::SPD_CNT_W;

  logic rst_meta_r, rst_pin_r, sck_meta_r, sck_r, sck_d_r, mosi_meta_r, mosi_r;
  logic rise, fall, byte_done, inst_done;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] rx_sh_r, rx_byte, b1_r, b2_r, b3_r;
  logic [7:0] tx_sh_r, tx_next_r, rd_val_r;
  logic load_pend_r, enabled_r, idle_ok, is_rd_fl;
  logic [7:0] pg_lo_r [spd_pkg::SPD_PAGE_WORDS];
  logic [7:0] pg_hi_r [spd_pkg::SPD_PAGE_WORDS];
  spd_state_t state_r;
  spd_busy_t bk_r;
  logic [spd_pkg::SPD_IDX_W-1:0] idx_r;
  logic [spd_pkg::SPD_PAGE_W-1:0] page_r;
  logic [spd_pkg::SPD_EE_AW-1:0] ee_addr_r;
  logic [7:0] ee_data_r;
  logic [spd_pkg::SPD_CNT_W-1:0] wait_cnt_r;
  logic rd_none_r, rd_hi_r, rd_hit;
  logic [spd_pkg::SPD_FL_AW-1:0] rd_addr_r;
  logic rd_ee_r;
  logic in_valid, in_ready;
  logic [spd_pkg::SPD_BUF_W-1:0] in_data, out_data;
  logic [1:0] in_op;
  logic [spd_pkg::SPD_FL_AW-1:0] in_addr;
  logic [15:0] in_word;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_meta_r <= 1'b1;
      rst_pin_r <= 1'b1;
      sck_meta_r <= 1'b0;
      sck_r <= 1'b0;
      sck_d_r <= 1'b0;
      mosi_meta_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      rst_meta_r <= prog_reset_n;
      rst_pin_r <= rst_meta_r;
      sck_meta_r <= sck;
      sck_r <= sck_meta_r;
      sck_d_r <= sck_r;
      mosi_meta_r <= mosi;
      mosi_r <= mosi_meta_r;
    end
  end

  // programming mode follows the synchronised reset pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) prog_mode <= 1'b0;
    else prog_mode <= ~rst_pin_r;
  end

  // edge detection works because each clock phase spans several cycles
  assign rise = prog_mode & sck_r & ~sck_d_r;
  assign fall = prog_mode & ~sck_r & sck_d_r;
  assign rx_byte = {rx_sh_r[6:0], mosi_r};
  assign byte_done = rise & (bit_cnt_r == 3'h7);
  assign inst_done = byte_done & (byte_cnt_r == 2'h3);
  assign is_rd_fl = ((b1_r & ~spd_pkg::SPD_HI_BIT_MASK) == spd_pkg::SPD_B1_RD_FL);

  // receive shifter; counters restart whenever the reset pin rises
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 2'h0;
      rx_sh_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
    end else if (!prog_mode) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 2'h0;
    end else if (rise) begin
      rx_sh_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        byte_cnt_r <= byte_cnt_r + 2'h1;
        if (byte_cnt_r == 2'h0) b1_r <= rx_byte;
        if (byte_cnt_r == 2'h1) b2_r <= rx_byte;
        if (byte_cnt_r == 2'h2) b3_r <= rx_byte;
      end
    end
  end

  // transmit: bytes one and two echo during the next; byte four carries read data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sh_r <= 8'h00;
      tx_next_r <= 8'h00;
      load_pend_r <= 1'b0;
    end else if (!prog_mode) begin
      tx_sh_r <= 8'h00;
      load_pend_r <= 1'b0;
    end else begin
      if (byte_done) begin
        tx_next_r <= (byte_cnt_r == 2'h3) ? spd_pkg::SPD_ZERO : rx_byte;
        load_pend_r <= 1'b1;
      end
      if (fall) begin
        load_pend_r <= 1'b0;
        if (load_pend_r && byte_cnt_r == 2'h3) tx_sh_r <= rd_val_r;
        else if (load_pend_r) tx_sh_r <= tx_next_r;
        else tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end
  assign miso = tx_sh_r[7];

  // enable latch: set by the full four-byte enable, cleared by leaving the mode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) enabled_r <= 1'b0;
    else if (!prog_mode) enabled_r <= 1'b0;
    else if (inst_done && b1_r == spd_pkg::SPD_B1_ENABLE && b2_r == spd_pkg::SPD_B2_ENABLE)
      enabled_r <= 1'b1;
  end

  // writes are only taken when enabled and the arrays are quiet
  assign idle_ok = enabled_r & ~busy;

  // read address is caught as byte three completes, ahead of byte four
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_r <= '0;
      rd_ee_r <= 1'b0;
      rd_hi_r <= 1'b0;
      rd_none_r <= 1'b1;
    end else if (byte_done && byte_cnt_r == 2'h2) begin
      rd_none_r <= 1'b1;
      if (enabled_r && is_rd_fl) begin
        rd_addr_r <= {b2_r[3:0], rx_byte};
        rd_ee_r <= 1'b0;
        rd_hi_r <= b1_r[3];
        rd_none_r <= 1'b0;
      end else if (enabled_r && b1_r == spd_pkg::SPD_B1_RD_EE) begin
        rd_addr_r <= {3'h0, b2_r[0], rx_byte};
        rd_ee_r <= 1'b1;
        rd_none_r <= 1'b0;
      end
    end
  end
  assign rd_addr = rd_addr_r;
  assign rd_ee = rd_ee_r;

  // polling view: locations under write read as all ones until the write ends
  always_comb begin
    rd_hit = 1'b0;
    if (busy) begin
      case (bk_r)
        BK_ERASE: rd_hit = 1'b1;
        BK_FLASH: rd_hit = ~rd_ee_r & (rd_addr_r[11:5] == page_r);
        default: rd_hit = rd_ee_r & (rd_addr_r[8:0] == ee_addr_r);
      endcase
    end
  end

  // read value register; the array answers within a cycle of the address
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) rd_val_r <= 8'h00;
    else if (rd_none_r) rd_val_r <= spd_pkg::SPD_ZERO;
    else if (rd_hit) rd_val_r <= spd_pkg::SPD_ERASED;
    else if (rd_ee_r) rd_val_r <= ee_rd_data;
    else rd_val_r <= rd_hi_r ? fl_rd_data[15:8] : fl_rd_data[7:0];
  end

  // page buffer, one byte per load instruction; starts erased
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < spd_pkg::SPD_PAGE_WORDS; i++) begin
        pg_lo_r[i] <= spd_pkg::SPD_ERASED;
        pg_hi_r[i] <= spd_pkg::SPD_ERASED;
      end
    end else if (inst_done && idle_ok && state_r == S_IDLE &&
                 (b1_r & ~spd_pkg::SPD_HI_BIT_MASK) == spd_pkg::SPD_B1_LD_PG) begin
      if (b1_r[3]) pg_hi_r[b3_r[4:0]] <= rx_byte;
      else pg_lo_r[b3_r[4:0]] <= rx_byte;
    end
  end

  // command sequencer: turns accepted writes into array operations
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      idx_r <= '0;
      page_r <= '0;
      ee_addr_r <= '0;
      ee_data_r <= 8'h00;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (inst_done && idle_ok) begin
            if (b1_r == spd_pkg::SPD_B1_ENABLE && b2_r[7:5] == spd_pkg::SPD_B2_ERASE) begin
              state_r <= S_ERASE;
            end else if (b1_r == spd_pkg::SPD_B1_WR_PG) begin
              page_r <= {b2_r[3:0], b3_r[7:5]};
              idx_r <= '0;
              state_r <= S_PAGE;
            end else if (b1_r == spd_pkg::SPD_B1_WR_EE) begin
              ee_addr_r <= {b2_r[0], b3_r};
              ee_data_r <= rx_byte;
              state_r <= S_EE_ERASE;
            end
          end
        end
        S_PAGE: begin
          if (in_ready) begin
            idx_r <= idx_r + 5'h1;
            if (idx_r == 5'(spd_pkg::SPD_PAGE_WORDS - 1)) state_r <= S_IDLE;
          end
        end
        S_EE_ERASE: if (in_ready) state_r <= S_EE_WRITE;
        S_EE_WRITE: if (in_ready) state_r <= S_IDLE;
        default: if (in_ready) state_r <= S_IDLE;
      endcase
    end
  end

  // self-timed write counter, armed with the kind of write it covers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt_r <= '0;
      bk_r <= BK_FLASH;
    end else if (state_r == S_IDLE && inst_done && idle_ok) begin
      if (b1_r == spd_pkg::SPD_B1_ENABLE && b2_r[7:5] == spd_pkg::SPD_B2_ERASE) begin
        wait_cnt_r <= SPD_CNT_W'(ERASE_CYC);
        bk_r <= BK_ERASE;
      end else if (b1_r == spd_pkg::SPD_B1_WR_PG) begin
        wait_cnt_r <= SPD_CNT_W'(FLASH_CYC);
        bk_r <= BK_FLASH;
      end else if (b1_r == spd_pkg::SPD_B1_WR_EE) begin
        wait_cnt_r <= SPD_CNT_W'(EE_CYC);
        bk_r <= BK_EE;
      end
    end else if (wait_cnt_r != '0) begin
      wait_cnt_r <= wait_cnt_r - SPD_CNT_W'(1);
    end
  end
  assign busy = (wait_cnt_r != '0) | (state_r != S_IDLE);

  // operation word pushed into the write buffer
  always_comb begin
    in_op = spd_pkg::SPD_OP_CHIP_ERASE;
    in_addr = '0;
    in_word = {8'h00, spd_pkg::SPD_ERASED};
    case (state_r)
      S_PAGE: begin
        in_op = spd_pkg::SPD_OP_FL_WORD;
        in_addr = {page_r, idx_r};
        in_word = {pg_hi_r[idx_r], pg_lo_r[idx_r]};
      end
      S_EE_ERASE: begin
        in_op = spd_pkg::SPD_OP_EE_ERASE;
        in_addr = {3'h0, ee_addr_r};
      end
      S_EE_WRITE: begin
        in_op = spd_pkg::SPD_OP_EE_WRITE;
        in_addr = {3'h0, ee_addr_r};
        in_word = {8'h00, ee_data_r};
      end
      default: begin
        in_op = spd_pkg::SPD_OP_CHIP_ERASE;
      end
    endcase
  end
  assign in_valid = (state_r != S_IDLE);
  assign in_data = {in_op, in_addr, in_word};

  // a stall by the array holds the sequencer, so no word is dropped
  spd_buf #(
    .W(spd_pkg::SPD_BUF_W),
    .DEPTH(2)
  ) u_buf (
    .clk(sys_clk),
    .rst(sys_rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(nvm_valid),
    .out_ready(nvm_ready),
    .out_data(out_data)
  );
  assign nvm_op = out_data[29:28];
  assign nvm_addr = out_data[27:16];
  assign nvm_data = out_data[15:0];
endmodule // spd_top
`default_nettype wire

// *** dv/spd_top_sva.sv ***
// concurrent checks on the serial program download port
`timescale 1ns/1ps
`default_nettype none
module spd_top_sva #(
  parameter int FLASH_CYC = 3000,
  parameter int EE_CYC = 3000,
  parameter int ERASE_CYC = 3000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic miso,
  // array write port
  input wire logic nvm_valid,
  input wire logic nvm_ready,
  input wire logic [1:0] nvm_op,
  input wire logic [spd_pkg::SPD_FL_AW-1:0] nvm_addr,
  input wire logic [15:0] nvm_data,
  // status
  input wire logic prog_mode,
  input wire logic busy
);
  localparam int MIN_A = FLASH_CYC < EE_CYC ? FLASH_CYC : EE_CYC;
  localparam int MIN_CYC = MIN_A < ERASE_CYC ? MIN_A : ERASE_CYC;
  logic [31:0] busy_len_r;
  logic [4:0] idx_r;
  logic [6:0] page_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // length of the current busy stretch
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_len_r <= 32'h0;
    end else begin
      busy_len_r <= busy ? busy_len_r + 32'h1 : 32'h0;
    end
  end
  // last flash word the array took; the page must be walked in order
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_r <= 5'h0;
      page_r <= 7'h0;
    end else if (nvm_valid && nvm_ready && nvm_op == 2'h0) begin
      idx_r <= nvm_addr[4:0];
      page_r <= nvm_addr[11:5];
    end
  end
  mode_entry_a: assert property (!prog_reset_n [*6] |-> prog_mode)
    else $error("prog mode missing while reset pin low");
  mode_exit_a: assert property (prog_reset_n [*4] |-> !prog_mode)
    else $error("prog mode held after reset pin high");
  stall_hold_a: assert property (nvm_valid && !nvm_ready |=>
    nvm_valid && $stable(nvm_op) && $stable(nvm_addr) && $stable(nvm_data))
    else $error("array op changed while stalled");
  miso_edge_a: assert property ($changed(miso) && !prog_reset_n
    && !$past(prog_reset_n, 8) |-> !sck && !$past(sck, 1))
    else $error("miso moved away from a falling clock");
  erase_first_a: assert property (nvm_valid && nvm_ready && nvm_op == 2'h1
    |-> ##[1:8] nvm_valid && nvm_op == 2'h2)
    else $error("eeprom write missing after erase");
  erase_data_a: assert property (nvm_valid && nvm_op == 2'h3 |-> nvm_data == 16'h00FF)
    else $error("chip erase data not all ones");
  busy_len_a: assert property ($fell(busy) |-> busy_len_r >= MIN_CYC - 2)
    else $error("busy ended too early");
  page_order_a: assert property (nvm_valid && nvm_op == 2'h0 && nvm_addr[4:0] != 5'h0
    |-> idx_r == nvm_addr[4:0] - 5'h1 && page_r == nvm_addr[11:5])
    else $error("page words out of order");
endmodule // spd_top_sva
bind spd_top spd_top_sva #(.FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC), .ERASE_CYC(ERASE_CYC))
  i_spd_top_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .prog_reset_n(prog_reset_n),
  .sck(sck), .miso(miso), .nvm_valid(nvm_valid), .nvm_ready(nvm_ready), .nvm_op(nvm_op),
  .nvm_addr(nvm_addr), .nvm_data(nvm_data), .prog_mode(prog_mode), .busy(busy));
`default_nettype wire

// *** dv/spd_prog_model.sv ***
// behavioural serial programmer driving the link pins
`timescale 1ns/1ps
`default_nettype none
module spd_prog_model (
  // system clock, only paces the link
  input wire logic clk,
  // link pins
  output logic prog_reset_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // power up with reset pin and clock low
  initial begin
    prog_reset_n <= 1'b0;
    sck <= 1'b0;
    mosi <= 1'b0;
  end
  // eight-cycle phases (an 80 ns link clock), well over the minimum
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      rx[i] = miso;
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  // whole instruction; the data line flips afterwards so nothing leans on it
  task automatic instr(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int b = 3; b >= 0; b--) begin
      xfer(cmd[b*8 +: 8], rsp[b*8 +: 8]);
    end
    mosi <= ~mosi;
    @(posedge clk);
  endtask
  // level of the reset pin
  task automatic set_reset(input logic lvl);
    prog_reset_n <= lvl;
  endtask
endmodule // spd_prog_model
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the serial program download port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic prog_reset_n, sck, mosi, miso, nvm_valid, rd_ee, prog_mode, busy;
  logic nvm_ready = 1'b0;
  logic [1:0] nvm_op;
  logic [11:0] nvm_addr, rd_addr;
  logic [15:0] nvm_data, fl_rd_data;
  logic [7:0] ee_rd_data;
  logic [15:0] fl_mem [4096];
  logic [7:0] ee_mem [512];
  int fail_count = 0;
  int checks = 0;
  int ops_n = 0;
  always #2.5 sys_clk = ~sys_clk;
  spd_top #(.FLASH_CYC(3000), .EE_CYC(3000), .ERASE_CYC(3000)) i_spd_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .prog_reset_n(prog_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso), .nvm_valid(nvm_valid), .nvm_ready(nvm_ready),
    .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .rd_addr(rd_addr),
    .rd_ee(rd_ee), .fl_rd_data(fl_rd_data), .ee_rd_data(ee_rd_data),
    .prog_mode(prog_mode), .busy(busy));
  spd_prog_model i_spd_prog_model (.clk(sys_clk), .prog_reset_n(prog_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso));
  assign fl_rd_data = fl_mem[rd_addr];
  assign ee_rd_data = ee_mem[rd_addr[8:0]];
  // array model; the write ands in, so a skipped erase shows up
  always @(posedge sys_clk) begin
    nvm_ready <= ($urandom_range(3) != 0);
    if (nvm_valid === 1'b1 && nvm_ready === 1'b1) begin
      ops_n <= ops_n + 1;
      case (nvm_op)
        2'h0: fl_mem[nvm_addr] <= nvm_data;
        2'h1: ee_mem[nvm_addr[8:0]] <= 8'hFF;
        2'h2: ee_mem[nvm_addr[8:0]] <= ee_mem[nvm_addr[8:0]] & nvm_data[7:0];
        default: begin
          for (int i = 0; i < 4096; i++) fl_mem[i] <= 16'hFFFF;
          for (int i = 0; i < 512; i++) ee_mem[i] <= 8'hFF;
        end
      endcase
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rd_fl(input logic [11:0] a, input logic hi);
    return {spd_pkg::SPD_B1_RD_FL | (hi ? spd_pkg::SPD_HI_BIT_MASK : 8'h00),
      4'h0, a[11:8], a[7:0], 8'h00};
  endfunction
  function automatic logic [31:0] ee_rd_inst(input logic [8:0] a);
    return {spd_pkg::SPD_B1_RD_EE, 7'h0, a[8], a[7:0], 8'h00};
  endfunction
  // bounded wait for the write sequencer to go quiet
  task automatic wait_idle;
    int n;
    n = 0;
    while ((busy !== 1'b0 || nvm_valid !== 1'b0) && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    check(busy, 1'b0);
  endtask
  // hang guard
  initial begin
    #450us;
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] w [32];
    logic [11:0] a;
    logic [8:0] ea;
    logic [7:0] ed;
    int n0;
    void'($urandom(18031));
    for (int i = 0; i < 4096; i++) fl_mem[i] = 16'($urandom);
    for (int i = 0; i < 512; i++) ee_mem[i] = 8'($urandom);
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // power-up settle before the enable; shortened, the port keeps no timer for it
    repeat (30) @(posedge sys_clk);
    #1.3;
    check(prog_mode, 1'b1);
    n0 = ops_n;
    i_spd_prog_model.instr({spd_pkg::SPD_B1_WR_EE, 24'h001000}, r);
    repeat (10) @(posedge sys_clk);
    check(16'(ops_n - n0), 16'h0);
    i_spd_prog_model.instr({spd_pkg::SPD_B1_ENABLE, spd_pkg::SPD_B2_ENABLE, 16'h5AA5}, r);
    check(r[23:16], spd_pkg::SPD_B1_ENABLE);
    check(r[15:8], spd_pkg::SPD_B2_ENABLE);
    n0 = ops_n;
    i_spd_prog_model.instr({spd_pkg::SPD_B1_ENABLE, spd_pkg::SPD_B2_ERASE, 21'h150000}, r);
    i_spd_prog_model.instr(rd_fl(12'($urandom), 1'b0), r);
    check(r[7:0], spd_pkg::SPD_ERASED);
    wait_idle();
    check(16'(ops_n - n0), 16'h1);
    i_spd_prog_model.instr(ee_rd_inst(9'($urandom)), r);
    check(r[7:0], spd_pkg::SPD_ERASED);
    check(rd_ee, 1'b1);
    // page load, low byte before high byte, last index is the boundary
    a = {7'($urandom), 5'h0};
    for (int i = 0; i < 32; i++) begin
      w[i] = 16'($urandom);
      i_spd_prog_model.instr({spd_pkg::SPD_B1_LD_PG, 11'h0, 5'(i), w[i][7:0]}, r);
      i_spd_prog_model.instr({spd_pkg::SPD_B1_LD_PG | spd_pkg::SPD_HI_BIT_MASK, 11'h0,
        5'(i), w[i][15:8]}, r);
    end
    i_spd_prog_model.instr({spd_pkg::SPD_B1_WR_PG, 4'h0, a[11:8], a[7:5], 13'h0}, r);
    i_spd_prog_model.instr(rd_fl(a | 12'h01F, 1'b1), r);
    check(r[7:0], spd_pkg::SPD_ERASED);
    check(rd_ee, 1'b0);
    wait_idle();
    foreach (w[i]) begin
      if (i % 8 == 0 || i == 31) begin
        i_spd_prog_model.instr(rd_fl(a | 12'(i), 1'b0), r);
        check(r[7:0], w[i][7:0]);
        i_spd_prog_model.instr(rd_fl(a | 12'(i), 1'b1), r);
        check(r[7:0], w[i][15:8]);
      end
    end
    // address 0x1FF written twice; the second write relies on the auto-erase
    for (int k = 0; k < 4; k++) begin
      ea = (k < 2) ? 9'h1FF : 9'($urandom);
      ed = 8'($urandom_range(254));
      i_spd_prog_model.instr({spd_pkg::SPD_B1_WR_EE, 7'h0, ea, ed}, r);
      i_spd_prog_model.instr(ee_rd_inst(ea), r);
      check(r[7:0], spd_pkg::SPD_ERASED);
      wait_idle();
      i_spd_prog_model.instr(ee_rd_inst(ea), r);
      check(r[7:0], ed);
    end
    i_spd_prog_model.set_reset(1'b1);
    repeat (10) @(posedge sys_clk);
    check(prog_mode, 1'b0);
    n0 = ops_n;
    i_spd_prog_model.instr({spd_pkg::SPD_B1_WR_EE, 24'h000155}, r);
    repeat (10) @(posedge sys_clk);
    check(16'(ops_n - n0), 16'h0);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
